// ===== hdl/oag_pkg.sv
package oag_pkg;
  // ==========================================================
  // prefix bytes
  localparam logic [7:0] prefix_swap_offset_reg = 8'h90;
  localparam logic [7:0] prefix_indirect_swap_reg = 8'h91;
  localparam logic [7:0] prefix_make_indirect = 8'h92;
  // ==========================================================
  // interrupt mask levels
  localparam logic [1:0] IRQ_LEVEL_MASKED = 2'h3;
  localparam logic [1:0] IRQ_LEVEL_OPEN = 2'h0;
  localparam logic [15:0] ZERO_PAGE_TOP = 16'h00FF;
  // ==========================================================
  // addressing modes: base modes from the opcode, indirect forms set by the prefix
  typedef enum logic [3:0] {
    OAG_INH = 4'h0, OAG_IMM = 4'h1, OAG_DIR_S = 4'h2, OAG_DIR_L = 4'h3,
    OAG_IDX_0 = 4'h4, OAG_IDX_S = 4'h5, OAG_IDX_L = 4'h6,
    OAG_IND_S = 4'h7, OAG_IND_L = 4'h8, OAG_IIX_S = 4'h9,
    OAG_IIX_L = 4'hA, OAG_REL_D = 4'hB, OAG_REL_I = 4'hC,
    OAG_BIT_D = 4'hD, OAG_BIT_I = 4'hE, OAG_BTR_D = 4'hF
  } oag_mode_t;
  // decode result handed from decoder to sequencer
  typedef struct packed {
    oag_mode_t mode;
    logic bit_rel_ind;  // bit indirect relative, the 17th mode
    logic use_y;
    logic rmw;
    logic illegal;
    logic mask_op;
    logic unmask_op;
  } oag_dec_t;
  // address result
  typedef struct packed {
    logic [15:0] addr;
    logic is_imm;
    logic is_pc;
  } oag_res_t;
endpackage

// ===== hdl/oag_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module oag_decoder
  import oag_pkg::*;
(
  input wire logic [7:0] prefix,
  input wire logic [7:0] opcode,
  output oag_dec_t dec
);
  // ==========================================================
  // opcode column picks base mode (high nibble), prefix adjusts it
  function automatic logic is_rmw(input logic [7:0] op);
    is_rmw = (op[7:4] == 4'h3) || (op[7:4] == 4'h6) || (op[7:4] == 4'h7)
      || (op[7:4] == 4'h0) || (op[7:4] == 4'h1);
  endfunction
  always_comb begin
    dec = '0;
    dec.rmw = is_rmw(opcode);
    dec.use_y = (prefix == prefix_swap_offset_reg)
      || (prefix == prefix_indirect_swap_reg);
    dec.mask_op = (opcode == 8'h9B);
    dec.unmask_op = (opcode == 8'h9A);
    case (opcode[7:4])
      4'h0: dec.mode = OAG_BTR_D;
      4'h1: dec.mode = OAG_BIT_D;
      4'h2: dec.mode = OAG_REL_D;
      4'h3: dec.mode = OAG_DIR_S;
      4'h4, 4'h5, 4'h8, 4'h9: dec.mode = OAG_INH;
      4'h6: dec.mode = OAG_IDX_S;
      4'h7: dec.mode = OAG_IDX_0;
      4'hA: dec.mode = OAG_IMM;
      4'hB: dec.mode = OAG_DIR_S;
      4'hC: dec.mode = OAG_DIR_L;
      4'hD: dec.mode = OAG_IDX_L;
      4'hE: dec.mode = OAG_IDX_S;
      4'hF: dec.mode = OAG_IDX_0;
      default: dec.mode = OAG_INH;
    endcase
    if (prefix == prefix_make_indirect) begin
      case (dec.mode)
        OAG_DIR_S: dec.mode = OAG_IND_S;
        OAG_DIR_L: dec.mode = OAG_IND_L;
        OAG_IDX_S: dec.mode = OAG_IIX_S;
        OAG_IDX_L: dec.mode = OAG_IIX_L;
        OAG_REL_D: dec.mode = OAG_REL_I;
        OAG_BIT_D: dec.mode = OAG_BIT_I;
        OAG_BTR_D: dec.bit_rel_ind = 1'b1;
        default: dec.illegal = 1'b1;
      endcase
    end
    // pointer-swap prefix only meaningful on indexed indirect
    if (prefix == prefix_indirect_swap_reg
        && dec.mode != OAG_IDX_S && dec.mode != OAG_IDX_L)
      dec.illegal = 1'b1;
    if (prefix == prefix_indirect_swap_reg) begin
      if (dec.mode == OAG_IDX_S)
        dec.mode = OAG_IIX_S;
      else if (dec.mode == OAG_IDX_L)
        dec.mode = OAG_IIX_L;
    end
    // long forms of read-modify-write are not encodable
    if (dec.rmw && (dec.mode == OAG_DIR_L || dec.mode == OAG_IDX_L
        || dec.mode == OAG_IND_L || dec.mode == OAG_IIX_L))
      dec.illegal = 1'b1;
  end
endmodule // oag_decoder
`default_nettype wire

// ===== hdl/oag_cpu_operand_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
module oag_cpu_operand_address_generator
  import oag_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] prefix,
  input wire logic [7:0] opcode,
  input wire logic [15:0] pc,
  input wire logic [7:0] index_x,
  input wire logic [7:0] index_y,
  output logic code_req,
  output logic [15:0] code_addr,
  input wire logic code_valid,
  input wire logic [7:0] code_data,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  output logic done,
  output oag_res_t result,
  output logic [7:0] imm_value,
  output logic [1:0] operand_bytes,
  output logic illegal,
  output logic [1:0] irq_level
);
  // ==========================================================
  // decode
  oag_dec_t dec;
  oag_dec_t cur;
  oag_decoder oag_decoder_i (
    .prefix(prefix),
    .opcode(opcode),
    .dec(dec)
  );
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_B1 = 6'b000010, S_B2 = 6'b000100,
    S_PH = 6'b001000, S_PL = 6'b010000, S_DONE = 6'b100000
  } oag_state_t;
  oag_state_t state;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] ph;
  logic [15:0] next_addr;
  logic [15:0] idx;
  logic [7:0] cb1; // first code byte, live while it is answered
  logic [7:0] cb2;
  // ==========================================================
  // byte count following the opcode
  function automatic logic [1:0] code_bytes(input oag_dec_t d);
    case (d.mode)
      OAG_INH, OAG_IDX_0: code_bytes = 2'h0;
      OAG_DIR_L, OAG_IDX_L: code_bytes = 2'h2;
      OAG_BTR_D: code_bytes = d.bit_rel_ind ? 2'h3 : 2'h2;
      default: code_bytes = 2'h1;
    endcase
  endfunction
  function automatic logic word_ptr(input oag_mode_t m);
    word_ptr = (m == OAG_IND_L) || (m == OAG_IIX_L);
  endfunction
  function automatic logic fetches_ptr(input oag_dec_t d);
    fetches_ptr = (d.mode == OAG_IND_S) || (d.mode == OAG_IND_L)
      || (d.mode == OAG_IIX_S) || (d.mode == OAG_IIX_L)
      || (d.mode == OAG_REL_I) || (d.mode == OAG_BIT_I)
      || d.bit_rel_ind;
  endfunction
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction
  assign idx = {8'h00, (cur.use_y ? index_y : index_x)};
  // bus data in the cycle it is taken, captured register afterwards
  assign cb1 = (state == S_B1) ? code_data : b1;
  assign cb2 = (state == S_B2) ? code_data : b2;
  // ==========================================================
  // sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (start) begin
            if (code_bytes(dec) == 2'h0)
              state <= S_DONE;
            else
              state <= S_B1;
          end
        end
        S_B1: begin
          if (code_valid) begin
            if (code_bytes(cur) == 2'h2 && !cur.bit_rel_ind)
              state <= S_B2;
            else if (fetches_ptr(cur))
              state <= word_ptr(cur.mode) ? S_PH : S_PL;
            else
              state <= S_DONE;
          end
        end
        S_B2: begin
          if (code_valid)
            state <= S_DONE;
        end
        S_PH: begin
          if (mem_valid)
            state <= S_PL;
        end
        S_PL: begin
          if (mem_valid)
            state <= S_DONE;
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end
  // latch decode at start
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      cur <= '0;
    else if (state == S_IDLE && start)
      cur <= dec;
  end
  // capture fetched bytes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      b1 <= 8'h00;
      b2 <= 8'h00;
      ph <= 8'h00;
    end else begin
      if (state == S_B1 && code_valid)
        b1 <= code_data;
      if (state == S_B2 && code_valid)
        b2 <= code_data;
      if (state == S_PH && mem_valid)
        ph <= mem_data;
    end
  end
  // ==========================================================
  // bus requests
  assign code_req = (state == S_B1) || (state == S_B2);
  assign code_addr = (state == S_B2) ? pc + 16'h0002 : pc + 16'h0001;
  assign mem_req = (state == S_PH) || (state == S_PL);
  assign mem_addr = (state == S_PL && word_ptr(cur.mode))
    ? {8'h00, b1} + 16'h0001 : {8'h00, b1};
  // ==========================================================
  // effective address forming
  always_comb begin
    next_addr = 16'h0000;
    case (cur.mode)
      OAG_DIR_S, OAG_BIT_D, OAG_BTR_D: next_addr = {8'h00, cb1};
      OAG_DIR_L: next_addr = {cb1, cb2};
      OAG_IDX_0: next_addr = idx;
      OAG_IDX_S: next_addr = idx + {8'h00, cb1};
      OAG_IDX_L: next_addr = idx + {cb1, cb2};
      OAG_IND_S, OAG_BIT_I: next_addr = {8'h00, mem_data};
      OAG_IND_L: next_addr = {ph, mem_data};
      OAG_IIX_S: next_addr = idx + {8'h00, mem_data};
      OAG_IIX_L: next_addr = idx + {ph, mem_data};
      OAG_REL_D: next_addr = pc + 16'h0002 + sext8(cb1);
      OAG_REL_I: next_addr = pc + 16'h0002 + sext8(mem_data);
      default: next_addr = 16'h0000;
    endcase
    if (cur.bit_rel_ind)
      next_addr = {8'h00, mem_data};
  end
  // result register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result <= '0;
      imm_value <= 8'h00;
    end else if ((state == S_B1 && code_valid && !fetches_ptr(cur)
                  && !(code_bytes(cur) == 2'h2 && !cur.bit_rel_ind))
                 || (state == S_B2 && code_valid)
                 || (state == S_PL && mem_valid)
                 || (state == S_DONE && cur.mode == OAG_IDX_0)) begin
      result.addr <= next_addr;
      result.is_imm <= (cur.mode == OAG_IMM);
      result.is_pc <= (cur.mode == OAG_REL_D) || (cur.mode == OAG_REL_I);
      if (cur.mode == OAG_IMM)
        imm_value <= cb1;
    end
  end
  // outputs of completion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      operand_bytes <= 2'h0;
      illegal <= 1'b0;
    end else begin
      done <= (state == S_DONE);
      if (state == S_IDLE && start) begin
        operand_bytes <= code_bytes(dec);
        illegal <= dec.illegal;
      end
    end
  end
  // interrupt mask level
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      irq_level <= IRQ_LEVEL_MASKED;
    else if (state == S_IDLE && start && dec.mask_op)
      irq_level <= IRQ_LEVEL_MASKED;
    else if (state == S_IDLE && start && dec.unmask_op)
      irq_level <= IRQ_LEVEL_OPEN;
  end
  // ==========================================================
  // checks
  property p_inh_done;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_INH) |=> ##1 done;
  endproperty
  a_inh_done: assert property (p_inh_done)
    else $error("inherent not done in two cycles");
  property p_mask;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mask_op) |=> irq_level == 2'h3;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask level wrong");
  property p_unmask;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.unmask_op) |=> irq_level == 2'h0;
  endproperty
  a_unmask: assert property (p_unmask)
    else $error("unmask level wrong");
  property p_short_zero;
    @(posedge clock) disable iff (!nrst)
      (done && (cur.mode == OAG_DIR_S || cur.mode == OAG_IND_S
       || cur.mode == OAG_IDX_0)) |-> result.addr <= ZERO_PAGE_TOP;
  endproperty
  a_short_zero: assert property (p_short_zero)
    else $error("short mode left zero page");
  property p_idx_short;
    @(posedge clock) disable iff (!nrst)
      (done && cur.mode == OAG_IDX_S) |-> result.addr <= 16'h01FE;
  endproperty
  a_idx_short: assert property (p_idx_short)
    else $error("indexed short out of range");
  property p_rmw_long;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.rmw) |=> illegal
        || (cur.mode != OAG_DIR_L && cur.mode != OAG_IDX_L
        && !word_ptr(cur.mode));
  endproperty
  a_rmw_long: assert property (p_rmw_long)
    else $error("long rmw not flagged");
  sequence s_ptr_word;
    (state == S_PH) ##[1:8] (state == S_PL);
  endsequence
  property p_word_ptr;
    @(posedge clock) disable iff (!nrst)
      (state == S_B1 && code_valid && word_ptr(cur.mode)) |=> s_ptr_word;
  endproperty
  a_word_ptr: assert property (p_word_ptr)
    else $error("word pointer not fetched in two parts");
  property p_code_count;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_IMM) |=>
        operand_bytes == 2'h1;
  endproperty
  a_code_count: assert property (p_code_count)
    else $error("immediate length wrong");
  // ==========================================================
  // operand field lengths and pointer fetch steps
  property p_dir_short_len;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_DIR_S) |=>
        operand_bytes == 2'h1;
  endproperty
  a_dir_short_len: assert property (p_dir_short_len)
    else $error("direct short length wrong");
  property p_dir_long_len;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_DIR_L) |=>
        operand_bytes == 2'h2;
  endproperty
  a_dir_long_len: assert property (p_dir_long_len)
    else $error("direct long length wrong");
  property p_idx_long_len;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_IDX_L) |=>
        operand_bytes == 2'h2;
  endproperty
  a_idx_long_len: assert property (p_idx_long_len)
    else $error("indexed long length wrong");
  property p_ind_len;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start
       && (dec.mode == OAG_IND_S || dec.mode == OAG_IIX_S)) |=>
        operand_bytes == 2'h1;
  endproperty
  a_ind_len: assert property (p_ind_len)
    else $error("indirect short length wrong");
  sequence s_idx0_done;
    (operand_bytes == 2'h0) ##1 (done && result.addr[15:8] == 8'h00);
  endsequence
  property p_idx0;
    @(posedge clock) disable iff (!nrst)
      (state == S_IDLE && start && dec.mode == OAG_IDX_0) |=> s_idx0_done;
  endproperty
  a_idx0: assert property (p_idx0)
    else $error("indexed without offset wrong");
  property p_ptr_addr;
    @(posedge clock) disable iff (!nrst)
      (state == S_B1 && code_valid && fetches_ptr(cur)) |=>
        mem_req && mem_addr == {8'h00, $past(code_data)};
  endproperty
  a_ptr_addr: assert property (p_ptr_addr)
    else $error("pointer fetched from wrong place");
  property p_ptr_low;
    @(posedge clock) disable iff (!nrst)
      (state == S_PH && mem_valid) |=> state == S_PL
        && ph == $past(mem_data) && mem_addr == {8'h00, b1} + 16'h0001;
  endproperty
  a_ptr_low: assert property (p_ptr_low)
    else $error("word pointer halves out of order");
  property p_iix_short;
    @(posedge clock) disable iff (!nrst)
      (done && cur.mode == OAG_IIX_S) |-> result.addr <= 16'h01FE;
  endproperty
  a_iix_short: assert property (p_iix_short)
    else $error("indirect indexed short out of range");
  property p_idx_sum;
    @(posedge clock) disable iff (!nrst)
      (done && cur.mode == OAG_IDX_S) |-> result.addr
        == {8'h00, (cur.use_y ? index_y : index_x)} + {8'h00, b1};
  endproperty
  a_idx_sum: assert property (p_idx_sum)
    else $error("indexed sum wrong");
  property p_rel_pc;
    @(posedge clock) disable iff (!nrst)
      (done && (cur.mode == OAG_REL_D || cur.mode == OAG_REL_I)) |->
        result.is_pc && !result.is_imm;
  endproperty
  a_rel_pc: assert property (p_rel_pc)
    else $error("relative result not marked");
  property p_imm_value;
    @(posedge clock) disable iff (!nrst)
      (state == S_B1 && code_valid && cur.mode == OAG_IMM) |=>
        imm_value == $past(code_data) && result.is_imm;
  endproperty
  a_imm_value: assert property (p_imm_value)
    else $error("immediate operand wrong");
  property p_long_ind;
    @(posedge clock) disable iff (!nrst)
      (done && cur.mode == OAG_IND_L) |-> result.addr[15:8] == ph;
  endproperty
  a_long_ind: assert property (p_long_ind)
    else $error("long pointer high byte wrong");
endmodule // oag_cpu_operand_address_generator
`default_nettype wire

// ===== tb/oag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// memory side: code bytes and pointer bytes, with a set wait
module oag_mem_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] latency,
  input wire logic code_req,
  input wire logic [15:0] code_addr,
  output logic code_valid,
  output logic [7:0] code_data,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_valid,
  output logic [7:0] mem_data
);
  logic [7:0] mem [0:65535];
  logic [1:0] code_wait;
  logic [1:0] data_wait;
  logic [7:0] junk;
  // junk pattern shown while no answer is given
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) junk <= 8'hA5;
    else junk <= junk + 8'h3B;
  end
  // wait counters, cleared once a byte is answered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      code_wait <= 2'h0;
      data_wait <= 2'h0;
    end else begin
      code_wait <= (code_req && !code_valid) ? code_wait + 2'h1 : 2'h0;
      data_wait <= (mem_req && !mem_valid) ? data_wait + 2'h1 : 2'h0;
    end
  end
  // answers, same cycle when latency is zero
  assign code_valid = code_req && (code_wait == latency);
  assign code_data = code_valid ? mem[code_addr] : junk;
  assign mem_valid = mem_req && (data_wait == latency);
  assign mem_data = mem_valid ? mem[mem_addr] : ~junk;
endmodule // oag_mem_model
`default_nettype wire

// ===== tb/tb_cpu_operand_address_generator.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench top
module tb_cpu_operand_address_generator;
  import oag_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [7:0] prefix = 8'h00;
  logic [7:0] opcode = 8'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0] index_x = 8'h00;
  logic [7:0] index_y = 8'h00;
  logic [1:0] latency = 2'h0;
  logic code_req, code_valid, mem_req, mem_valid, done, illegal;
  logic [15:0] code_addr, mem_addr;
  logic [7:0] code_data, mem_data, imm_value;
  logic [1:0] operand_bytes, irq_level;
  oag_res_t result;
  logic [1:0] irq_exp = 2'h3;
  logic [7:0] ref_mem [0:65535];
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 94492;
  logic [15:0] ops [0:28] = '{16'h0080, 16'h009A, 16'h009B, 16'h0042,
    16'h00A6, 16'h90A6, 16'h00B6, 16'h00C6, 16'h00F6, 16'h90F6, 16'h00E6,
    16'h90E6, 16'h00D6, 16'h90D6, 16'h92B6, 16'h92C6, 16'h92E6, 16'h91E6,
    16'h92D6, 16'h91D6, 16'h0020, 16'h9220, 16'h0010, 16'h0030, 16'h9230,
    16'h91B6, 16'h0000, 16'h9200, 16'h9210};
  // clock of 20 ns
  always #10 clock = ~clock;
  oag_cpu_operand_address_generator oag_cpu_operand_address_generator_i (
    .clock(clock), .nrst(nrst), .start(start), .prefix(prefix),
    .opcode(opcode), .pc(pc), .index_x(index_x), .index_y(index_y),
    .code_req(code_req), .code_addr(code_addr), .code_valid(code_valid),
    .code_data(code_data), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_valid(mem_valid), .mem_data(mem_data), .done(done),
    .result(result), .imm_value(imm_value), .operand_bytes(operand_bytes),
    .illegal(illegal), .irq_level(irq_level));
  oag_mem_model oag_mem_model_i (
    .clock(clock), .nrst(nrst), .latency(latency), .code_req(code_req),
    .code_addr(code_addr), .code_valid(code_valid), .code_data(code_data),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_valid(mem_valid),
    .mem_data(mem_data));
  // ==========================================================
  // compare and close
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic poke(input logic [15:0] a, input logic [7:0] v);
    ref_mem[a] = v;
    oag_mem_model_i.mem[a] = v;
  endtask
  // ==========================================================
  // one instruction: model, drive, compare
  task automatic run(input logic [7:0] p, input logic [7:0] o,
                     input int pass, input bit hold);
    logic [7:0] b1, b2, ptr, idx, r;
    logic [15:0] ea, w;
    logic [3:0] hi;
    int nb, nf, n;
    bit ind, isimm, ispc, ill, got;
    @(negedge clock);
    pc = {2'b10, 14'($random(seed))};
    index_x = 8'($random(seed));
    index_y = 8'($random(seed));
    latency = 2'($random(seed));
    if (latency == 2'h3) latency = 2'h0;
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    hi = o[7:4];
    ind = (p == 8'h92) || (p == 8'h91);
    if (pass == 0) begin
      index_x = 8'hFF;
      index_y = 8'hFF;
      b1 = 8'hFF;
      b2 = 8'hFF;
    end
    if (ind && (hi == 4'hC || hi == 4'hD) && b1 == 8'hFF) b1 = 8'hFE;
    idx = (p == 8'h90 || p == 8'h91) ? index_y : index_x;
    poke(pc + 16'h0001, b1);
    poke(pc + 16'h0002, b2);
    poke({8'h00, b1}, (pass == 0) ? 8'hFF : 8'($random(seed)));
    poke({8'h00, b1 + 8'h01}, 8'($random(seed)));
    ptr = ref_mem[{8'h00, b1}];
    w = {ptr, ref_mem[{8'h00, b1 + 8'h01}]};
    nb = 1;
    nf = ind ? 1 : 0;
    ea = 16'h0000;
    isimm = 0;
    ispc = 0;
    ill = (p == 8'h91) && (hi != 4'hD) && (hi != 4'hE);
    r = ind ? ptr : b1;
    case (hi)
      4'hA: isimm = 1;
      4'hB, 4'h3, 4'h1: ea = {8'h00, r};
      4'h0: begin
        ea = {8'h00, r};
        nb = ind ? 1 : 2;
      end
      4'hC, 4'hD: begin
        ea = (ind ? w : {b1, b2}) + ((hi == 4'hD) ? {8'h00, idx} : 16'h0);
        nb = ind ? 1 : 2;
        nf = ind ? 2 : 0;
      end
      4'hE: ea = {8'h00, r} + {8'h00, idx};
      4'hF: begin
        ea = {8'h00, idx};
        nb = 0;
      end
      4'h2: begin
        ea = pc + 16'h0002 + {{8{r[7]}}, r};
        ispc = 1;
      end
      default: begin
        nb = 0;
        nf = 0;
        if (o == 8'h9B) irq_exp = IRQ_LEVEL_MASKED;
        if (o == 8'h9A) irq_exp = IRQ_LEVEL_OPEN;
      end
    endcase
    prefix = p;
    opcode = o;
    start = 1'b1;
    @(posedge clock);
    n = 0;
    got = 0;
    while (!got && n < 40) begin
      @(negedge clock);
      start = hold && (n == 0);
      if (hold) opcode = 8'h80;
      @(posedge clock);
      #1;
      n++;
      got = (done === 1'b1);
    end
    check("done_seen", got, 1);
    if (!ill) begin
      check("cycles", n, 1 + (nb + nf) * (1 + latency));
      check("operand_bytes", operand_bytes,
            (hi == 4'h0 && ind) ? 3 : nb);
      check("is_imm", result.is_imm, isimm);
      check("is_pc", result.is_pc, ispc);
      if (isimm) check("imm_value", imm_value, b1);
      else if (nb + nf > 0 || hi == 4'hF)
        check("addr", result.addr, ea);
    end
    check("illegal", illegal, ill);
    check("irq_level", irq_level, irq_exp);
    @(posedge clock);
    #1;
    check("done_pulse", done, 0);
  endtask
  // ==========================================================
  // watchdog
  initial begin
    #1000000;
    n_mismatch++;
    $display("Error watchdog expected end seen hang");
    end_of_test();
  end
  // main sequence: reset, then every mode in several passes
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    check("irq_reset", irq_level, IRQ_LEVEL_MASKED);
    check("done_reset", done, 0);
    for (int pass = 0; pass < 8; pass++) begin
      for (int k = 0; k < 29; k++) begin
        run(ops[k][15:8], ops[k][7:0], pass, (pass == 1) && (k == 7));
      end
    end
    end_of_test();
  end
endmodule // tb_cpu_operand_address_generator
`default_nettype wire
